// >>> src/tcit_top.sv
`timescale 1ns/1ps
module tcit_top
    import tcit_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire tcit_host_s host_req,
    output logic [7:0] host_rdata,
    input wire logic [2:0] count_clk,
    input wire logic [2:0] gate,
    output logic [2:0] timer_out
);

    // ----------------------------------------------------------------
    // control word decode
    // ----------------------------------------------------------------
    tcit_ctl_s ctl;
    logic [1:0] ctl_sel;
    tcit_access_e ctl_acc;
    tcit_mode_e ctl_mode;
    logic ctl_wr;
    logic readback;
    logic [7:0] rd_byte [NUM_CH];
    logic [7:0] rdata_ff;

    assign ctl = host_req.wdata;
    assign ctl_sel = {ctl.counter_select_high, ctl.counter_select_low};
    assign ctl_acc = tcit_access_e'({ctl.access_format_high, ctl.access_format_low});
    // the top mode bit is a don't care for rate and square
    assign ctl_mode = ctl.count_mode_bit1 ? tcit_mode_e'({1'b0, ctl.count_mode_bit1, ctl.count_mode_bit0})
                                          : tcit_mode_e'({ctl.count_mode_bit2, 1'b0, ctl.count_mode_bit0});
    assign ctl_wr = host_req.wr && (host_req.addr == OFS_CTL);
    assign readback = ctl_wr && (ctl_sel == SEL_READBACK);

    // ----------------------------------------------------------------
    // read data register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_ff <= RDATA_RST;
        end else if (ce && host_req.rd) begin
            if (host_req.addr == OFS_CH0) begin
                rdata_ff <= rd_byte[0];
            end else if (host_req.addr == OFS_CH1) begin
                rdata_ff <= rd_byte[1];
            end else if (host_req.addr == OFS_CH2) begin
                rdata_ff <= rd_byte[2];
            end else begin
                rdata_ff <= CTL_READ_VAL; // write-only control word
            end
        end
    end

    assign host_rdata = rdata_ff;

    // ----------------------------------------------------------------
    // counter channels
    // ----------------------------------------------------------------
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        tcit_mode_e mode_ff;
        tcit_access_e access_ff;
        logic bcd_ff;
        logic [15:0] count_ff;
        logic [15:0] init_ff;
        logic [15:0] latch_ff;
        logic latched_ff;
        logic wr_msb_ff;
        logic rd_msb_ff;
        logic load_pend_ff;
        logic hold_ff;
        logic armed_ff;
        logic run_ff;
        logic out_ff;
        logic clk_prev_ff;
        logic gate_prev_ff;
        logic trig_ff;
        logic cfg_hit;
        logic latch_hit;
        logic data_wr;
        logic data_rd;
        logic wr_done;
        logic rd_done;
        logic tick;
        logic [1:0] dec_amt;
        logic [15:0] nxt_dec;
        logic [15:0] rd_word;

        assign cfg_hit = ctl_wr && (ctl_sel == 2'(g)) && (ctl_acc != ACC_LATCH);
        assign latch_hit = (ctl_wr && (ctl_sel == 2'(g)) && (ctl_acc == ACC_LATCH))
                         || (readback && host_req.wdata[RB_CH0_POS+g] && !host_req.wdata[RB_COUNT_N_POS]);
        assign data_wr = host_req.wr && (host_req.addr == 2'(g));
        assign data_rd = host_req.rd && (host_req.addr == 2'(g));
        assign wr_done = data_wr && ((access_ff != ACC_WORD) || wr_msb_ff);
        assign rd_done = data_rd && ((access_ff != ACC_WORD) || rd_msb_ff);
        assign tick = count_clk[g] && !clk_prev_ff;

        // square wave: odd counts lose one in the high phase and three in the low phase
        assign dec_amt = (mode_ff != MODE_SQUARE) ? DEC_ONE
                       : (!count_ff[0] ? DEC_TWO : (out_ff ? DEC_ONE : DEC_THREE));

        tcit_dec u_dec (
            .value(count_ff),
            .decimal(bcd_ff),
            .amount(dec_amt),
            .result(nxt_dec)
        );

        // ------------------------------------------------------------
        // configuration
        // ------------------------------------------------------------
        always_ff @(posedge clk) begin
            if (srst) begin
                mode_ff <= MODE_TC;
                access_ff <= ACC_LOW;
                bcd_ff <= 1'b0;
            end else if (ce && cfg_hit) begin
                mode_ff <= ctl_mode;
                access_ff <= ctl_acc;
                bcd_ff <= ctl.decimal;
            end
        end

        // ------------------------------------------------------------
        // divisor write path
        // ------------------------------------------------------------
        always_ff @(posedge clk) begin
            if (srst) begin
                init_ff <= COUNT_RST;
                wr_msb_ff <= 1'b0;
                load_pend_ff <= 1'b0;
                hold_ff <= 1'b1;
            end else if (ce) begin
                if (cfg_hit) begin
                    wr_msb_ff <= 1'b0;
                    load_pend_ff <= 1'b0;
                    hold_ff <= 1'b1; // no counting until a divisor arrives
                end else if (data_wr) begin
                    if (access_ff == ACC_LOW) begin
                        init_ff <= {8'h00, host_req.wdata};
                    end else if (access_ff == ACC_HIGH) begin
                        init_ff <= {host_req.wdata, 8'h00};
                    end else if (!wr_msb_ff) begin
                        init_ff[7:0] <= host_req.wdata;
                        wr_msb_ff <= 1'b1;
                        if (mode_ff == MODE_TC) begin
                            hold_ff <= 1'b1;
                        end
                    end else begin
                        init_ff[15:8] <= host_req.wdata;
                        wr_msb_ff <= 1'b0;
                    end
                    if (wr_done) begin
                        load_pend_ff <= 1'b1; // set wins over the tick clear
                        hold_ff <= 1'b0;
                    end
                end else if (tick) begin
                    load_pend_ff <= 1'b0;
                end
            end
        end

        // ------------------------------------------------------------
        // count read path and latch
        // ------------------------------------------------------------
        always_ff @(posedge clk) begin
            if (srst) begin
                latch_ff <= COUNT_RST;
                latched_ff <= 1'b0;
                rd_msb_ff <= 1'b0;
            end else if (ce) begin
                if (cfg_hit) begin
                    latched_ff <= 1'b0;
                    rd_msb_ff <= 1'b0;
                end else if (latch_hit) begin
                    // a second latch before reading keeps the first value
                    if (!latched_ff) begin
                        latch_ff <= count_ff;
                        latched_ff <= 1'b1;
                    end
                end else if (data_rd) begin
                    if (access_ff == ACC_WORD) begin
                        rd_msb_ff <= !rd_msb_ff;
                    end
                    if (rd_done) begin
                        latched_ff <= 1'b0;
                    end
                end
            end
        end

        assign rd_word = latched_ff ? latch_ff : count_ff;
        assign rd_byte[g] = ((access_ff == ACC_HIGH) || ((access_ff == ACC_WORD) && rd_msb_ff))
                          ? rd_word[15:8] : rd_word[7:0];

        // ------------------------------------------------------------
        // count clock and gate edges
        // ------------------------------------------------------------
        always_ff @(posedge clk) begin
            if (srst) begin
                clk_prev_ff <= 1'b0;
                gate_prev_ff <= 1'b0;
                trig_ff <= 1'b0;
            end else if (ce) begin
                clk_prev_ff <= count_clk[g];
                gate_prev_ff <= gate[g];
                if (gate[g] && !gate_prev_ff) begin
                    trig_ff <= 1'b1; // set wins over the tick clear
                end else if (tick || cfg_hit) begin
                    trig_ff <= 1'b0;
                end
            end
        end

        // ------------------------------------------------------------
        // counting and output
        // ------------------------------------------------------------
        always_ff @(posedge clk) begin
            if (srst) begin
                count_ff <= COUNT_RST;
                out_ff <= OUT_RST;
                armed_ff <= 1'b0;
                run_ff <= 1'b0;
            end else if (ce) begin
                if (cfg_hit) begin
                    out_ff <= (ctl_mode != MODE_TC);
                    armed_ff <= 1'b0;
                    run_ff <= 1'b0;
                end else begin
                    if (data_wr && (mode_ff == MODE_TC)) begin
                        out_ff <= 1'b0; // first byte drops the output at once
                    end
                    if (wr_done && ((mode_ff == MODE_ONESHOT) || (mode_ff == MODE_HWSTROBE))) begin
                        armed_ff <= 1'b1;
                    end
                    if (tick && !data_wr) begin
                        case (mode_ff)
                            MODE_TC: begin
                                if (load_pend_ff) begin
                                    count_ff <= init_ff;
                                    out_ff <= 1'b0;
                                end else if (gate[g] && !hold_ff) begin
                                    count_ff <= nxt_dec;
                                    if (count_ff == CNT_ONE) begin
                                        out_ff <= 1'b1;
                                    end
                                end
                            end
                            MODE_SWSTROBE: begin
                                if (load_pend_ff) begin
                                    count_ff <= init_ff;
                                    out_ff <= 1'b1;
                                    run_ff <= 1'b1;
                                end else if (gate[g] && !hold_ff) begin
                                    count_ff <= nxt_dec;
                                    out_ff <= !(run_ff && (count_ff == CNT_ONE));
                                    if (count_ff == CNT_ONE) begin
                                        run_ff <= 1'b0;
                                    end
                                end
                            end
                            MODE_RATE: begin
                                // divisor of one would never show a low pulse
                                if (!gate[g] || hold_ff) begin
                                    out_ff <= 1'b1;
                                end else if (load_pend_ff || (count_ff == CNT_ONE)) begin
                                    count_ff <= init_ff;
                                    out_ff <= 1'b1;
                                end else begin
                                    count_ff <= nxt_dec;
                                    out_ff <= (count_ff != CNT_TWO);
                                end
                            end
                            MODE_SQUARE: begin
                                if (!gate[g] || hold_ff) begin
                                    out_ff <= 1'b1;
                                end else if (load_pend_ff) begin
                                    count_ff <= init_ff;
                                    out_ff <= 1'b1;
                                end else if (count_ff == {14'h0000, dec_amt}) begin
                                    count_ff <= init_ff;
                                    out_ff <= !out_ff;
                                end else begin
                                    count_ff <= nxt_dec;
                                end
                            end
                            default: begin
                                // one-shot and hardware strobe start on a gate rise
                                if (trig_ff && armed_ff) begin
                                    count_ff <= init_ff;
                                    out_ff <= (mode_ff != MODE_ONESHOT);
                                    run_ff <= 1'b1;
                                end else if (run_ff) begin
                                    count_ff <= nxt_dec;
                                    if (count_ff == CNT_ONE) begin
                                        run_ff <= 1'b0;
                                        out_ff <= (mode_ff == MODE_ONESHOT);
                                    end
                                end else if (mode_ff == MODE_HWSTROBE) begin
                                    out_ff <= 1'b1;
                                end
                            end
                        endcase
                    end
                end
            end
        end

        assign timer_out[g] = out_ff;
    end

endmodule

// >>> src/tcit_pkg.sv
// Contract
// - three independent counters, each sixteen bits wide and separately configured.
// - divisors from 2 to 65535 are accepted; software programs only that range.
// - four byte locations: offsets 0..2 counter data ports, offset 3 control word.
// - data port writes load divisor bytes; data port reads return count bytes.
// - configuration is set only by a control word write, before the divisor.
// - control word: selector 7:6 (11 read-back), access 5:4, mode 3:1, decimal 0.
// - access 00 latches count, 01 low byte, 10 high byte, 11 low then high.
// - mode field picks terminal count, one-shot, rate, square, software or hardware strobe.
// - decimal flag clear counts binary sixteen bit, set counts four decimal digits.
package tcit_pkg;

    // ----------------------------------------------------------------
    // sizes and register offsets
    // ----------------------------------------------------------------
    localparam int NUM_CH = 3;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam logic [1:0] OFS_CH0 = 2'h0;
    localparam logic [1:0] OFS_CH1 = 2'h1;
    localparam logic [1:0] OFS_CH2 = 2'h2;
    localparam logic [1:0] OFS_CTL = 2'h3;

    // ----------------------------------------------------------------
    // control word fields
    // ----------------------------------------------------------------
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam int RB_COUNT_N_POS = 5;
    localparam int RB_CH0_POS = 1;

    // ----------------------------------------------------------------
    // reset values and constants
    // ----------------------------------------------------------------
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic [7:0] CTL_READ_VAL = 8'h00;
    localparam logic OUT_RST = 1'b0;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_TWO = 16'h0002;
    localparam logic [15:0] DIV_MIN = 16'h0002;
    localparam logic [15:0] DIV_MAX = 16'hFFFF;
    localparam logic [1:0] DEC_ONE = 2'h1;
    localparam logic [1:0] DEC_TWO = 2'h2;
    localparam logic [1:0] DEC_THREE = 2'h3;
    localparam logic [4:0] BCD_TEN = 5'h0A;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_LATCH = 2'b00,
        ACC_LOW = 2'b01,
        ACC_HIGH = 2'b10,
        ACC_WORD = 2'b11
    } tcit_access_e;

    typedef enum logic [2:0] {
        MODE_TC = 3'b000,
        MODE_ONESHOT = 3'b001,
        MODE_RATE = 3'b010,
        MODE_SQUARE = 3'b011,
        MODE_SWSTROBE = 3'b100,
        MODE_HWSTROBE = 3'b101
    } tcit_mode_e;

    typedef struct packed {
        logic counter_select_high;
        logic counter_select_low;
        logic access_format_high;
        logic access_format_low;
        logic count_mode_bit2;
        logic count_mode_bit1;
        logic count_mode_bit0;
        logic decimal;
    } tcit_ctl_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } tcit_host_s;

endpackage

// >>> src/tcit_dec.sv
`timescale 1ns/1ps
module tcit_dec
    import tcit_pkg::*;
(
    input wire logic [15:0] value,
    input wire logic decimal,
    input wire logic [1:0] amount,
    output logic [15:0] result
);

    // ----------------------------------------------------------------
    // binary and decimal subtract by one to three
    // ----------------------------------------------------------------
    logic [15:0] bin_res;
    logic [15:0] bcd_res;
    logic [4:0] borrow;

    assign bin_res = value - {14'h0000, amount};
    assign borrow[0] = 1'b0;

    for (genvar d = 0; d < 4; d++) begin : g_digit
        logic [4:0] diff;
        logic [4:0] fixed;
        // digit-wise borrow chain, each digit wraps at ten
        assign diff = {1'b0, value[4*d+3:4*d]} - ((d == 0) ? {3'h0, amount} : 5'h00) - {4'h0, borrow[d]};
        assign fixed = diff + BCD_TEN;
        assign borrow[d+1] = diff[4];
        assign bcd_res[4*d+3:4*d] = diff[4] ? fixed[3:0] : diff[3:0];
    end

    assign result = decimal ? bcd_res : bin_res;

endmodule

// >>> dv/tcit_top_asserts.sv
`timescale 1ns/1ps
module tcit_top_asserts
    import tcit_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire tcit_host_s host_req,
    input wire logic [7:0] host_rdata,
    input wire logic [2:0] count_clk,
    input wire logic [2:0] gate,
    input wire logic [2:0] timer_out
);
    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    logic [2:0] cc_q;
    logic [2:0] gate_q;
    logic [2:0] mode_q [3];
    logic [2:0] tick;
    logic [2:0] strobe_md;
    logic [2:0] low_tick;
    logic ev;
    logic ctl_cfg;

    assign tick = count_clk & ~cc_q;
    assign ev = ce && (host_req.wr || (|tick) || (|(gate ^ gate_q)));
    assign ctl_cfg = host_req.wr && host_req.addr == OFS_CTL && host_req.wdata[7:6] != SEL_READBACK
        && host_req.wdata[5:4] != 2'h0;
    // modes whose low phase ends on the very next tick
    for (genvar i = 0; i < 3; i++) begin : g_md
        assign strobe_md[i] = mode_q[i] inside {3'h2, 3'h4, 3'h5, 3'h6};
    end
    assign low_tick = ~timer_out & tick & strobe_md;

    // frozen with ce low, as the design's own edge samplers are
    always_ff @(posedge clk) begin
        if (srst) begin
            cc_q <= 3'h0;
            gate_q <= 3'h0;
        end else if (ce) begin
            cc_q <= count_clk;
            gate_q <= gate;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_q <= '{default: 3'h0};
        end else if (ce && ctl_cfg) begin
            mode_q[host_req.wdata[7:6]] <= host_req.wdata[3:1];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_reset_idle_values: assert property ($fell(srst) |-> host_rdata == RDATA_RST && timer_out == 3'h0)
        else $error("outputs not idle after reset");
    a_ctl_read_zero: assert property (ce && host_req.rd && host_req.addr == OFS_CTL |=> host_rdata == CTL_READ_VAL)
        else $error("control word read not zero");
    a_rdata_holds: assert property (!(ce && host_req.rd) |=> $stable(host_rdata))
        else $error("read data moved without a read");
    a_ce_freezes_all: assert property (!ce |=> $stable(timer_out) && $stable(host_rdata))
        else $error("state moved with ce low");
    a_out_has_cause: assert property ($changed(timer_out) |-> $past(ev) || $past(ev, 2))
        else $error("timer output changed without tick write or gate");
    a_ctl_sets_out: assert property (ce && ctl_cfg |=>
        timer_out[$past(host_req.wdata[7:6])] == ($past(host_req.wdata[3:1]) != 3'h0))
        else $error("initial output level wrong after control word");
    a_mode0_write_low: assert property (ce && host_req.wr && host_req.addr != OFS_CTL
        && mode_q[host_req.addr] == 3'h0 |=> !timer_out[$past(host_req.addr)])
        else $error("mode zero output not low after data write");
    a_strobe_one_tick: assert property (ce && !host_req.wr && (|low_tick) |=>
        (timer_out & $past(low_tick)) == $past(low_tick))
        else $error("low strobe lasted beyond one tick");

    c_data_read: cover property (ce && host_req.rd && host_req.addr != OFS_CTL);
    c_out_fall: cover property ($fell(timer_out[0]));
    c_ce_low: cover property (!ce);
endmodule

bind tcit_top tcit_top_asserts u_chk (.clk(clk), .srst(srst), .ce(ce), .host_req(host_req),
    .host_rdata(host_rdata), .count_clk(count_clk), .gate(gate), .timer_out(timer_out));

// >>> dv/tcit_host_bfm.sv
`timescale 1ns/1ps
module tcit_host_bfm
    import tcit_pkg::*;
(
    input wire logic clk,
    output tcit_host_s host_req,
    input wire logic [7:0] host_rdata
);
    initial host_req = '{wr: 1'b0, rd: 1'b0, addr: 2'h0, wdata: 8'h00};

    // one-cycle strobe; released address and data lines show the inverse, never the old value
    task automatic cycle(input logic w, input logic [1:0] a, input logic [7:0] d);
        @(negedge clk);
        host_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        cycle(1'b1, a, d);
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        cycle(1'b0, a, 8'h00);
        d = host_rdata;
    endtask

    task automatic prog(input logic [1:0] ch, input logic [7:0] ctl, input logic [15:0] div);
        wr(OFS_CTL, ctl);
        if (ctl[4]) wr(ch, div[7:0]);
        if (ctl[5]) wr(ch, div[15:8]);
    endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import tcit_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    tcit_host_s host_req;
    logic [7:0] host_rdata;
    logic [2:0] count_clk = 3'h0;
    logic [2:0] gate = 3'h0;
    logic [2:0] timer_out;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 69;
    logic [7:0] rb;
    logic [15:0] rv;
    logic [15:0] n;
    logic [15:0] exp_q [$];

    tcit_top uut (.clk(clk), .srst(srst), .ce(ce), .host_req(host_req), .host_rdata(host_rdata),
        .count_clk(count_clk), .gate(gate), .timer_out(timer_out));
    tcit_host_bfm host (.clk(clk), .host_req(host_req), .host_rdata(host_rdata));

    initial forever #20 clk = ~clk;

    // ------------------------------------------------------------
    // reference model and helpers
    // ------------------------------------------------------------
    // output level k ticks after load (or trigger); only even divisors, so mode 3 is exact
    function automatic logic exp_out(int m, int k, int d);
        case (m)
            0: return k >= d + 1;
            1: return k == 0 || k >= d + 1;
            2: return ((k - 1) % d) != d - 1;
            3: return ((k - 1) % d) < d / 2;
            default: return k != d + 1;
        endcase
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // high for two clocks so the sampler cannot miss it
    task automatic tick(input logic [1:0] ch);
        @(negedge clk);
        count_clk[ch] <= 1'b1;
        repeat (2) @(negedge clk);
        count_clk[ch] <= 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic rd16(input logic [1:0] ch);
        host.rd(ch, rb);
        rv[7:0] = rb;
        host.rd(ch, rb);
        rv[15:8] = rb;
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        logic [1:0] ch;
        repeat (5) @(posedge clk);
        @(negedge clk);
        srst <= 1'b0;
        @(negedge clk);
        check("rdata_rst", 16'(host_rdata), 16'h0000);
        check("out_rst", 16'(timer_out), 16'h0000);
        // every mode, spread over all three counters
        for (int m = 0; m < 6; m++) begin
            ch = 2'(m % 3);
            n = 16'(2 + 2 * ($random(seed) & 3));
            gate[ch] <= (m != 1 && m != 5);
            // rate generator sent with the don't care top mode bit set
            host.prog(ch, {ch, 2'b11, (m == 2) ? 3'h6 : m[2:0], 1'b0}, n);
            if (m == 1 || m == 5) begin
                @(negedge clk);
                gate[ch] <= 1'b1;
            end
            check("out_init", 16'(timer_out[ch]), 16'(exp_out(m, 0, int'(n))));
            for (int k = 1; k <= 2 * n + 2; k++) begin
                tick(ch);
                check("out_tick", 16'(timer_out[ch]), 16'(exp_out(m, k, int'(n))));
            end
        end
        // word access count with latch and read-back latch
        n = {8'h01, 8'($random(seed))};
        host.prog(2'h1, 8'h70, n);
        repeat (3) tick(2'h1);
        host.wr(OFS_CTL, 8'h40);
        exp_q.push_back(n - 16'h0002);
        tick(2'h1);
        exp_q.push_back(n - 16'h0003);
        rd16(2'h1);
        check("latched", rv, exp_q.pop_front());
        rd16(2'h1);
        check("live", rv, exp_q.pop_front());
        host.wr(OFS_CTL, 8'hC4);
        exp_q.push_back(n - 16'h0003);
        tick(2'h1);
        rd16(2'h1);
        check("readback", rv, exp_q.pop_front());
        // decimal counting, low byte only
        host.prog(2'h2, 8'h91, 16'h0010);
        repeat (4) tick(2'h2);
        host.rd(2'h2, rb);
        check("bcd_low", 16'(rb), 16'h0007);
        // high byte only
        host.prog(2'h0, 8'h20, 16'h0200);
        repeat (2) tick(2'h0);
        host.rd(2'h0, rb);
        check("high_only", 16'(rb), 16'h0001);
        host.rd(OFS_CTL, rb);
        check("ctl_read", 16'(rb), 16'h0000);
        // idle hold with the enable low: a whole count pulse is missed
        @(negedge clk);
        ce <= 1'b0;
        tick(2'h2);
        ce <= 1'b1;
        host.rd(2'h2, rb);
        check("ce_hold", 16'(rb), 16'h0007);
        summarize();
    end
endmodule
